// file: mca_status_and_dac_regs.sv
// Purpose: Host I/O port status word, control word and level registers
// Assumes: Host strobes are synchronous one-cycle pulses
// Notes:   Time counters are loaded from the RAM path via load strobes

`timescale 1ns/10ps

module mca_status_and_dac_regs import mca_pkg::*; #(
	parameter int MS_CYCLES = MS_CYC
) (
	input  wire logic        clock,
	input  wire host_req_t   req,
	input  wire logic        rst,
	output logic [15:0]      rd_data,
	output dac_set_t         dac,
	input  wire logic        ram_read_busy,
	input  wire logic        gate_in,
	input  wire logic        adc_dead,
	input  wire logic        aux_pin_in,
	output logic             aux_pin_out,
	output logic             aux_pin_oe,
	output logic             conv_enable,
	output logic             card_reset,
	output logic             irq_clear,
	input  wire logic        rt_load,
	input  wire logic        lt_load,
	input  wire logic [31:0] time_value,
	output logic [31:0]      real_time,
	output logic [31:0]      live_time,
	output logic [14:0]      range_chans,
	output logic [13:0]      offset_base
);

	// --------------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------------
	function automatic logic byte_wr(input host_req_t r, input logic [2:0] a);
		return r.wr & ~r.wide & (r.addr == a);
	endfunction

	function automatic logic [14:0] chans_of(input logic [2:0] code);
		logic [2:0] c;
		c = (code > RANGE_MAX) ? RANGE_MAX : code;
		// Widened sum: the base exponent does not fit the three-bit code
		return 15'h0001 << (4'(c) + 4'(MIN_CHANS_LOG));
	endfunction

	logic        ctrl_wr;
	logic        stat_rd;
	logic [15:0] ctrl_q;
	logic        irq_clr_q;
	acq_t        acq_q;
	logic [31:0] rt_q;
	logic [31:0] lt_q;
	logic [31:0] ms_cnt_q;
	logic [31:0] live_cnt_q;
	logic        ms_tick;
	logic        live_tick;
	logic        rt_wrap;
	logic        lt_wrap;
	logic        preset_stop;
	logic        wmod_q;
	logic [2:0]  settle_q;
	logic [15:0] status;
	logic [15:0] rd_q;
	dac_set_t    dac_q;

	assign ctrl_wr = req.wr & req.wide & (req.addr == OFS_STATE);
	assign stat_rd = req.rd & req.wide & (req.addr == OFS_STATE);

	// --------------------------------------------------------------------
	// Control word
	// --------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= req.data;
		end
	end

	// Interrupt clear is a self-clearing pulse
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_clr_q <= 1'b0;
		end else begin
			irq_clr_q <= ctrl_wr & req.data[B_RDFLAG];
		end
	end

	// --------------------------------------------------------------------
	// Level registers
	// --------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			dac_q <= '{DAC_RESET, DAC_RESET, DAC_RESET, DAC_RESET};
		end else begin
			if (byte_wr(req, OFS_AOUT)) begin
				dac_q.aout <= req.data[7:0];
			end
			if (byte_wr(req, OFS_ZERO)) begin
				dac_q.zero <= req.data[7:0];
			end
			if (byte_wr(req, OFS_LOWER)) begin
				dac_q.lower <= req.data[7:0];
			end
			if (byte_wr(req, OFS_UPPER)) begin
				dac_q.upper <= req.data[7:0];
			end
		end
	end

	// --------------------------------------------------------------------
	// Acquisition state
	// --------------------------------------------------------------------
	// A host write in the same cycle as a preset stop takes priority
	always_ff @(posedge clock) begin
		if (rst || ctrl_q[B_CRESET]) begin
			acq_q <= ACQ_IDLE;
		end else if (ctrl_wr) begin
			acq_q <= req.data[B_ACQ] ? ACQ_RUN : ACQ_IDLE;
		end else begin
			unique case (acq_q)
				ACQ_IDLE: acq_q <= ACQ_IDLE;
				ACQ_RUN:  acq_q <= preset_stop ? ACQ_IDLE : ACQ_RUN;
				default:  acq_q <= ACQ_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------------
	// Millisecond time bases
	// --------------------------------------------------------------------
	assign ms_tick   = (acq_q == ACQ_RUN) && (ms_cnt_q == 32'(MS_CYCLES - 1));
	assign live_tick = (acq_q == ACQ_RUN) && !adc_dead
		&& (live_cnt_q == 32'(MS_CYCLES - 1));

	always_ff @(posedge clock) begin
		if (rst || acq_q != ACQ_RUN || ms_tick) begin
			ms_cnt_q <= 32'h00000000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 32'h00000001;
		end
	end

	// Live time only accrues while the converter is free
	always_ff @(posedge clock) begin
		if (rst || acq_q != ACQ_RUN || live_tick) begin
			live_cnt_q <= 32'h00000000;
		end else if (!adc_dead) begin
			live_cnt_q <= live_cnt_q + 32'h00000001;
		end
	end

	// --------------------------------------------------------------------
	// Time counters and presets
	// --------------------------------------------------------------------
	assign rt_wrap = ms_tick && (rt_q == 32'hFFFFFFFF);
	assign lt_wrap = live_tick && (lt_q == 32'hFFFFFFFF);
	assign preset_stop = (rt_wrap && ctrl_q[B_PRE_RT])
		|| (lt_wrap && ctrl_q[B_PRE_LT]);

	always_ff @(posedge clock) begin
		if (rst) begin
			rt_q <= 32'h00000000;
		end else if (rt_load) begin
			rt_q <= time_value;
		end else if (ms_tick) begin
			rt_q <= rt_q + 32'h00000001;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			lt_q <= 32'h00000000;
		end else if (lt_load) begin
			lt_q <= time_value;
		end else if (live_tick) begin
			lt_q <= lt_q + 32'h00000001;
		end
	end

	// --------------------------------------------------------------------
	// Transfer mode follows direction after a settle time
	// --------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			settle_q <= 3'h0;
			wmod_q   <= 1'b0;
		end else if (wmod_q == ctrl_q[B_DIR] || ram_read_busy) begin
			settle_q <= 3'h0;
		end else if (settle_q == WMOD_SETTLE - 3'h1) begin
			settle_q <= 3'h0;
			wmod_q   <= ctrl_q[B_DIR];
		end else begin
			settle_q <= settle_q + 3'h1;
		end
	end

	// --------------------------------------------------------------------
	// Status word
	// --------------------------------------------------------------------
	always_comb begin
		status              = ctrl_q;
		status[B_RDFLAG]    = ram_read_busy;
		status[B_WMOD]      = wmod_q;
		status[B_ACQ]       = (acq_q == ACQ_RUN);
		status[B_CRESET]    = ctrl_q[B_CRESET];
		status[B_AUX]       = aux_pin_in;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_q <= 16'h0000;
		end else if (req.rd) begin
			rd_q <= stat_rd ? status : 16'h0000;
		end
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	assign rd_data     = rd_q;
	assign dac         = dac_q;
	assign aux_pin_out = 1'b0;
	assign aux_pin_oe  = ctrl_q[B_AUX];
	assign conv_enable = (acq_q == ACQ_RUN) && (gate_in ^ ctrl_q[B_ANTI]);
	assign card_reset  = ctrl_q[B_CRESET];
	assign irq_clear   = irq_clr_q;
	assign real_time   = rt_q;
	assign live_time   = lt_q;
	assign range_chans = chans_of(ctrl_q[B_RANGE +: 3]);
	assign offset_base = 14'({ctrl_q[B_OFFSET +: 4], 10'h000});

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence word_read_s;
		req.rd && req.wide && req.addr == OFS_STATE;
	endsequence

	status_read_a: assert property (word_read_s |=> rd_data == $past(status))
		else $error("status word read wrong");

	rt_stop_a: assert property (acq_q == ACQ_RUN && ctrl_q[0] && rt_wrap && !ctrl_wr
		|=> acq_q == ACQ_IDLE)
		else $error("real time preset did not stop");

	rt_advance_a: assert property (ms_tick && !rt_load |=> rt_q == $past(rt_q) + 32'h1)
		else $error("real time not advanced");

	lt_stop_a: assert property (acq_q == ACQ_RUN && ctrl_q[1] && lt_wrap && !ctrl_wr
		|=> acq_q == ACQ_IDLE)
		else $error("live time preset did not stop");

	rdflag_bit_a: assert property (word_read_s |=> rd_data[2] == $past(ram_read_busy))
		else $error("read flag mismatch");

	wmod_follow_a: assert property ((ctrl_q[7] != wmod_q && !ram_read_busy && !ctrl_wr) [*4]
		|=> wmod_q == ctrl_q[7])
		else $error("transfer mode did not follow");

	acq_bit_a: assert property (ctrl_wr && !ctrl_q[6] ##1 word_read_s
		|=> rd_data[4] == $past(req.data[4], 2))
		else $error("acquire bit not reported");

	gate_pol_a: assert property (conv_enable == (status[B_ACQ]
		&& (ctrl_q[B_ANTI] ? !gate_in : gate_in)))
		else $error("gate polarity wrong");

	ctrl_echo_a: assert property (ctrl_wr ##1 word_read_s
		|=> rd_data[14:8] == $past(req.data[14:8], 2))
		else $error("control echo wrong");

	dac_load_a: assert property (req.wr && !req.wide && req.addr == OFS_LOWER
		|=> dac.lower == $past(req.data[7:0]))
		else $error("lower level not loaded");

	range_top_a: assert property (ctrl_q[10:8] == 3'h6 |-> range_chans == 15'h4000)
		else $error("range 6 not 16k");

endmodule

// file: mca_pkg.sv
// Purpose: Constants and carrier types for the analyser card status and level registers
// Assumes: Single 25 MHz clock, synchronous active-high reset
// Notes:   Offsets are byte I/O offsets from the card base address

package mca_pkg;

	// --------------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------------
	localparam logic [2:0] OFS_STATE = 3'h0;
	localparam logic [2:0] OFS_AOUT  = 3'h1;
	localparam logic [2:0] OFS_ZERO  = 3'h3;
	localparam logic [2:0] OFS_LOWER = 3'h5;
	localparam logic [2:0] OFS_UPPER = 3'h7;

	// --------------------------------------------------------------------
	// Control and status bit positions
	// --------------------------------------------------------------------
	localparam int B_PRE_RT  = 0;
	localparam int B_PRE_LT  = 1;
	localparam int B_RDFLAG  = 2;
	localparam int B_WMOD    = 3;
	localparam int B_ACQ     = 4;
	localparam int B_ANTI    = 5;
	localparam int B_CRESET  = 6;
	localparam int B_DIR     = 7;
	localparam int B_RANGE   = 8;
	localparam int B_OFFSET  = 11;
	localparam int B_AUX     = 15;

	// --------------------------------------------------------------------
	// Reset values, limits and timing
	// --------------------------------------------------------------------
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [7:0]  DAC_RESET  = 8'h00;
	localparam logic [2:0]  RANGE_MAX  = 3'h6;
	localparam int          MIN_CHANS_LOG = 8;
	localparam int          OFF_STEP_LOG  = 10;
	localparam int          CLK_NS     = 40;
	localparam int          MS_NS      = 1000000;
	localparam int          MS_CYC     = MS_NS / CLK_NS;
	localparam logic [2:0]  WMOD_SETTLE = 3'h4;

	// --------------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        wide;
		logic [2:0]  addr;
		logic [15:0] data;
	} host_req_t;

	typedef struct packed {
		logic [7:0] aout;
		logic [7:0] zero;
		logic [7:0] lower;
		logic [7:0] upper;
	} dac_set_t;

	typedef enum logic [1:0] {
		ACQ_IDLE = 2'b01,
		ACQ_RUN  = 2'b10
	} acq_t;

endpackage

// file: mca_host_model.sv
// Purpose: Host side of the card I/O port, issuing word and byte cycles
// Assumes: Requests change 1 ns after a rising edge and last one cycle
// Notes:   Read data is taken just after the edge that samples the read

`timescale 1ns/10ps

module mca_host_model import mca_pkg::*; (
	input  wire logic        clock,
	input  wire logic [15:0] rd_data,
	output host_req_t        req
);
	initial begin
		req = '0;
	end

	// ------------------------------------------------------------
	// Port cycles
	// ------------------------------------------------------------
	task automatic io(input logic w, wide, input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		#1 req = '{rd: ~w, wr: w, wide: wide, addr: a, data: d};
		@(posedge clock);
		#1 req = '0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		io(1'b0, 1'b1, a, 16'h0000);
		d = rd_data;
	endtask

	// Polls status until the masked bits match, bounded
	task automatic poll(input logic [15:0] m, v, output logic ok);
		logic [15:0] s;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			rd(OFS_STATE, s);
			ok = ((s & m) === v);
		end
	endtask
endmodule

// file: tb_mca_status_and_dac_regs.sv
// Purpose: Self-checking bench for the status, control and level registers
// Assumes: Aux pin is open drain with a pull-up
// Notes:   Millisecond prescale shortened to MSC cycles

`timescale 1ns/10ps

module tb_mca_status_and_dac_regs import mca_pkg::*; ();
	localparam int MSC = 8;
	typedef struct {
		logic [15:0] ctrl;
		logic [15:0] stat;
		logic [14:0] chans;
		logic [13:0] offs;
	} row_t;
	row_t row_q [7] = '{
		'{16'h0000, 16'h8000, 15'h0100, 14'h0000},
		'{16'h00A3, 16'h80AB, 15'h0100, 14'h0000},
		'{16'h0610, 16'h8610, 15'h4000, 14'h0000},
		'{16'h7F00, 16'hFF00, 15'h4000, 14'h3C00},
		'{16'h8050, 16'h0040, 15'h0100, 14'h0000},
		'{16'h0500, 16'h8500, 15'h2000, 14'h0000},
		'{16'h4820, 16'hC820, 15'h0100, 14'h2400}};
	logic [2:0]  ofs_q [4] = '{OFS_AOUT, OFS_ZERO, OFS_LOWER, OFS_UPPER};
	logic        clock, rst, ram_read_busy, gate_in, adc_dead, aux_pin_in;
	logic        aux_pin_out, aux_pin_oe, conv_enable, card_reset, irq_clear;
	logic        rt_load, lt_load, ok;
	logic [31:0] time_value, real_time, live_time;
	logic [15:0] rd_data, d;
	logic [14:0] range_chans;
	logic [13:0] offset_base;
	host_req_t   req;
	dac_set_t    dac;
	int          failures, n_checks;
	logic [31:0] k;

	assign aux_pin_in = aux_pin_oe ? aux_pin_out : 1'b1;

	mca_host_model i_mca_host_model (.clock(clock), .rd_data(rd_data), .req(req));

	mca_status_and_dac_regs #(.MS_CYCLES(MSC)) i_mca_status_and_dac_regs (
		.clock(clock), .req(req), .rst(rst), .rd_data(rd_data), .dac(dac),
		.ram_read_busy(ram_read_busy), .gate_in(gate_in), .adc_dead(adc_dead),
		.aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe),
		.conv_enable(conv_enable), .card_reset(card_reset), .irq_clear(irq_clear),
		.rt_load(rt_load), .lt_load(lt_load), .time_value(time_value),
		.real_time(real_time), .live_time(live_time), .range_chans(range_chans),
		.offset_base(offset_base));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wrc(input logic [15:0] v);
		i_mca_host_model.io(1'b1, 1'b1, OFS_STATE, v);
	endtask

	task automatic load_t(input logic rt);
		time_value = 32'hFFFFFFFF;
		rt_load = rt;
		lt_load = ~rt;
		tick(1);
		rt_load = 1'b0;
		lt_load = 1'b0;
	endtask

	task automatic conclude();
		$display("Checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		#200000;
		failures++;
		conclude();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{ram_read_busy, gate_in, adc_dead, rt_load, lt_load} = '0;
		time_value = 32'h0;
		repeat (16) @(posedge clock);
		#1 rst = 1'b0;
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8000);
		chk(dac, 32'h0);
		chk(range_chans, 15'h0100);
		foreach (row_q[i]) begin
			wrc(row_q[i].ctrl);
			tick(6);
			i_mca_host_model.rd(OFS_STATE, d);
			chk(d, row_q[i].stat);
			chk(range_chans, row_q[i].chans);
			chk(offset_base, row_q[i].offs);
			chk({card_reset, aux_pin_oe}, {row_q[i].ctrl[6], row_q[i].ctrl[15]});
		end
		foreach (ofs_q[i]) i_mca_host_model.io(1'b1, 1'b0, ofs_q[i], 16'h0F5A + 16'(i));
		chk(dac, 32'h5A5B5C5D);
		i_mca_host_model.io(1'b1, 1'b0, OFS_STATE, 16'h00FF);
		i_mca_host_model.io(1'b1, 1'b1, OFS_AOUT, 16'h0011);
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'hC820);
		chk(dac.aout, 8'h5A);
		i_mca_host_model.rd(OFS_AOUT, d);
		chk(d, 16'h0000);
		ram_read_busy = 1'b1;
		wrc(16'h0080);
		tick(8);
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8084);
		ram_read_busy = 1'b0;
		i_mca_host_model.poll(16'h000C, 16'h0008, ok);
		chk(ok, 1'b1);
		wrc(16'h0004);
		k = irq_clear;
		tick(1);
		k += irq_clear;
		tick(1);
		k += irq_clear;
		chk(k, 1);
		gate_in = 1'b1;
		wrc(16'h0010);
		tick(1);
		chk(conv_enable, 1'b1);
		gate_in = 1'b0;
		tick(1);
		chk(conv_enable, 1'b0);
		wrc(16'h0030);
		tick(1);
		chk(conv_enable, 1'b1);
		wrc(16'h0000);
		load_t(1'b1);
		wrc(16'h0011);
		tick(3 * MSC);
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8001);
		chk(real_time, 32'h0);
		wrc(16'h0000);
		load_t(1'b0);
		adc_dead = 1'b1;
		wrc(16'h0012);
		tick(5 * MSC);
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8012);
		chk(live_time, 32'hFFFFFFFF);
		adc_dead = 1'b0;
		tick(3 * MSC);
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8002);
		chk(live_time, 32'h0);
		chk(real_time, 32'h00000006);
		// Reset with acquisition idle clears the control word, levels and counters
		wrc(16'h7F23);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		i_mca_host_model.rd(OFS_STATE, d);
		chk(d, 16'h8000);
		chk(dac, 32'h0);
		chk(real_time, 32'h00000000);
		chk(range_chans, 15'h0100);
		chk(offset_base, 14'h0000);
		conclude();
	end
endmodule
